// ### phycm_regs.sv
// Purpose: counter select, readback, interrupt mask and control registers
// Assumes: utility bus pins synchronous to mclk, held several cycles
// Notes:   ad bus split into in, out and output enable
// Notes on behaviour
// - offset 0x05 reads bits 15:8 of the selected counter
// - offset 0x04 reads bits 7:0 of the selected counter
// - write-only one-hot selector at 0x06, bits 3..0, resets to zero
// - received-cell counter never counts cells with a header check error
// - mask register at 0x07 holds six mask bits, bits 7:6 reserved
// - mask bit 1 blocks its status from the interrupt pin, 0 passes
// - interrupt status bits are sticky, reset to zero, hold until cleared
// - writing 1 to control bit 7 resets the device, bit self-clears
// - control bit 6 picks oscillator (0) or recovered clock (1)
// - control bits 4:0 hold the shared utopia port address
module phycm_regs
	import phycm_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    cs_n,
	input  wire logic                    ale,
	input  wire logic                    rd_n,
	input  wire logic                    wr_n,
	input  wire logic [PHYCM_DATA_W-1:0] ad_in,
	output logic      [PHYCM_DATA_W-1:0] ad_out,
	output logic                         ad_oe,
	input  wire logic                    symbol_err_evt,
	input  wire logic                    tx_cell_evt,
	input  wire logic                    rx_cell_evt,
	input  wire logic                    rx_cell_hec_bad,
	input  wire logic                    rx_hec_err_evt,
	input  wire logic [PHYCM_NIRQ-1:0]   irq_event,
	output logic      [PHYCM_NIRQ-1:0]   irq_status,
	output logic                         int_req,
	output logic                         soft_reset,
	output logic                         tx_clk_from_rx,
	output logic      [PHYCM_PORT_W-1:0] utopia_port_addr,
	input  wire logic [PHYCM_PORT_W-1:0] tx_addr_in,
	input  wire logic [PHYCM_PORT_W-1:0] rx_addr_in,
	output logic                         tx_addr_match,
	output logic                         rx_addr_match
);

	// ---------------------------------------------------------------
	// bus front end
	// ---------------------------------------------------------------
	logic [PHYCM_ADDR_W-1:0] addr_reg;
	logic [PHYCM_ADDR_W-1:0] addr_next;
	logic                    wr_n_reg;
	logic                    rd_n_reg;
	logic [PHYCM_DATA_W-1:0] rdata_reg;
	logic [PHYCM_DATA_W-1:0] rdata_next;
	logic                    wr_stb;
	logic                    rd_end;

	assign wr_stb = !cs_n && wr_n && !wr_n_reg;
	assign rd_end = !cs_n && rd_n && !rd_n_reg;

	always_comb begin
		addr_next = addr_reg;
		if (ale) begin
			addr_next = ad_in[PHYCM_ADDR_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// control state
	// ---------------------------------------------------------------
	logic [PHYCM_SEL_W-1:0]  sel_reg;
	logic [PHYCM_SEL_W-1:0]  sel_next;
	logic [PHYCM_NIRQ-1:0]   mask_reg;
	logic [PHYCM_NIRQ-1:0]   mask_next;
	logic                    loopclk_reg;
	logic                    loopclk_next;
	logic [PHYCM_PORT_W-1:0] port_reg;
	logic [PHYCM_PORT_W-1:0] port_next;
	logic                    swrst_reg;
	logic                    swrst_next;
	logic                    int_reg;
	logic                    int_next;

	always_comb begin
		sel_next     = sel_reg;
		mask_next    = mask_reg;
		loopclk_next = loopclk_reg;
		port_next    = port_reg;
		swrst_next   = 1'b0;
		if (wr_stb) begin
			if (addr_reg == PHYCM_OFF_CNT_SEL) begin
				sel_next = ad_in[PHYCM_SEL_W-1:0];
			end else if (addr_reg == PHYCM_OFF_IRQ_MASK) begin
				mask_next = ad_in[PHYCM_NIRQ-1:0];
			end else if (addr_reg == PHYCM_OFF_CONTROL) begin
				swrst_next   = ad_in[PHYCM_CTL_SWRST];
				loopclk_next = ad_in[PHYCM_CTL_LOOPCLK];
				port_next    = ad_in[PHYCM_CTL_PORT_HI:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// statistics counters
	// ---------------------------------------------------------------
	logic [PHYCM_NCNT-1:0]  cnt_inc;
	logic [PHYCM_CNT_W-1:0] cnt_val [PHYCM_NCNT];
	logic [PHYCM_CNT_W-1:0] cnt_sel_val;

	always_comb begin
		cnt_inc                   = '0;
		cnt_inc[PHYCM_SEL_SYMBOL] = symbol_err_evt;
		cnt_inc[PHYCM_SEL_TXCELL] = tx_cell_evt;
		cnt_inc[PHYCM_SEL_RXCELL] = rx_cell_evt && !rx_cell_hec_bad;
		cnt_inc[PHYCM_SEL_HECERR] = rx_hec_err_evt;
	end

	for (genvar i = 0; i < PHYCM_NCNT; i++) begin : g_cnt
		phycm_counter u_cnt (
			.mclk  (mclk),
			.rst_n (rst_n),
			.clr   (swrst_reg),
			.inc   (cnt_inc[i]),
			.count (cnt_val[i])
		);
	end

	// one-hot select; several bits set give the OR of counters
	always_comb begin
		cnt_sel_val = PHYCM_RST_COUNT;
		for (int k = 0; k < PHYCM_NCNT; k++) begin
			if (sel_reg[k]) begin
				cnt_sel_val = cnt_sel_val | cnt_val[k];
			end
		end
	end

	// ---------------------------------------------------------------
	// sticky interrupt status
	// ---------------------------------------------------------------
	logic stat_clr;

	assign stat_clr = swrst_reg || (rd_end && addr_reg == PHYCM_OFF_IRQ_STATUS);

	for (genvar j = 0; j < PHYCM_NIRQ; j++) begin : g_irq
		phycm_sticky u_flag (
			.mclk  (mclk),
			.rst_n (rst_n),
			.set   (irq_event[j]),
			.clr   (stat_clr),
			.flag  (irq_status[j])
		);
	end

	assign int_next = |(irq_status & ~mask_reg);

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = PHYCM_READ_ZERO;
		if (addr_reg == PHYCM_OFF_CNT_LOW) begin
			rdata_next = cnt_sel_val[7:0];
		end else if (addr_reg == PHYCM_OFF_CNT_HIGH) begin
			rdata_next = cnt_sel_val[15:8];
		end else if (addr_reg == PHYCM_OFF_IRQ_STATUS) begin
			rdata_next[PHYCM_NIRQ-1:0] = irq_status;
		end else if (addr_reg == PHYCM_OFF_IRQ_MASK) begin
			rdata_next[PHYCM_NIRQ-1:0] = mask_reg;
		end else if (addr_reg == PHYCM_OFF_CONTROL) begin
			rdata_next[PHYCM_CTL_LOOPCLK]  = loopclk_reg;
			rdata_next[PHYCM_CTL_PORT_HI:0] = port_reg;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_reg    <= '0;
			wr_n_reg    <= 1'b1;
			rd_n_reg    <= 1'b1;
			rdata_reg   <= PHYCM_READ_ZERO;
			sel_reg     <= PHYCM_RST_CNT_SEL;
			mask_reg    <= PHYCM_RST_MASK;
			loopclk_reg <= PHYCM_RST_LOOPCLK;
			port_reg    <= PHYCM_RST_PORT;
			swrst_reg   <= 1'b0;
			int_reg     <= 1'b0;
		end else begin
			addr_reg    <= addr_next;
			wr_n_reg    <= wr_n;
			rd_n_reg    <= rd_n;
			rdata_reg   <= rdata_next;
			sel_reg     <= sel_next;
			mask_reg    <= mask_next;
			loopclk_reg <= loopclk_next;
			port_reg    <= port_next;
			swrst_reg   <= swrst_next;
			int_reg     <= int_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign ad_out           = rdata_reg;
	assign ad_oe            = !cs_n && !rd_n && !ale;
	assign int_req          = int_reg;
	assign soft_reset       = swrst_reg;
	assign tx_clk_from_rx   = loopclk_reg;
	assign utopia_port_addr = port_reg;
	assign tx_addr_match    = (tx_addr_in == port_reg);
	assign rx_addr_match    = (rx_addr_in == port_reg);

endmodule : phycm_regs

// ### phycm_pkg.sv
// Purpose: shared constants of the counter, mask and control register bank
// Assumes: 8-bit multiplexed utility bus, 5-bit register address
// Notes:   register offsets are byte addresses on that bus
package phycm_pkg;

	localparam int unsigned PHYCM_ADDR_W = 5;
	localparam int unsigned PHYCM_DATA_W = 8;
	localparam int unsigned PHYCM_CNT_W  = 16;
	localparam int unsigned PHYCM_NCNT   = 4;
	localparam int unsigned PHYCM_NIRQ   = 6;
	localparam int unsigned PHYCM_PORT_W = 5;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] PHYCM_OFF_IRQ_STATUS = 5'h01;
	localparam logic [4:0] PHYCM_OFF_CNT_LOW    = 5'h04;
	localparam logic [4:0] PHYCM_OFF_CNT_HIGH   = 5'h05;
	localparam logic [4:0] PHYCM_OFF_CNT_SEL    = 5'h06;
	localparam logic [4:0] PHYCM_OFF_IRQ_MASK   = 5'h07;
	localparam logic [4:0] PHYCM_OFF_CONTROL    = 5'h08;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned PHYCM_SEL_SYMBOL  = 3;
	localparam int unsigned PHYCM_SEL_TXCELL  = 2;
	localparam int unsigned PHYCM_SEL_RXCELL  = 1;
	localparam int unsigned PHYCM_SEL_HECERR  = 0;
	localparam int unsigned PHYCM_SEL_W       = 4;

	localparam int unsigned PHYCM_IRQ_HEC     = 5;
	localparam int unsigned PHYCM_IRQ_SHORT   = 4;
	localparam int unsigned PHYCM_IRQ_TXPAR   = 3;
	localparam int unsigned PHYCM_IRQ_SIGCHG  = 2;
	localparam int unsigned PHYCM_IRQ_SYMERR  = 1;
	localparam int unsigned PHYCM_IRQ_FIFOOVF = 0;

	localparam int unsigned PHYCM_CTL_SWRST   = 7;
	localparam int unsigned PHYCM_CTL_LOOPCLK = 6;
	localparam int unsigned PHYCM_CTL_PORT_HI = 4;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  PHYCM_RST_CNT_SEL = 4'h0;
	localparam logic [5:0]  PHYCM_RST_MASK    = 6'h00;
	localparam logic        PHYCM_RST_LOOPCLK = 1'b0;
	localparam logic [4:0]  PHYCM_RST_PORT    = 5'h00;
	localparam logic [15:0] PHYCM_RST_COUNT   = 16'h0000;
	localparam logic [7:0]  PHYCM_READ_ZERO   = 8'h00;

endpackage : phycm_pkg

// ### phycm_cells.sv
// Purpose: statistics counter and sticky flag cells
// Assumes: synchronous active-low reset on mclk
// Notes:   clear wins in the counter, set wins in the flag
module phycm_counter
	import phycm_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   clr,
	input  wire logic                   inc,
	output logic [PHYCM_CNT_W-1:0]      count
);

	logic [PHYCM_CNT_W-1:0] count_reg;
	logic [PHYCM_CNT_W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clr) begin
			count_next = PHYCM_RST_COUNT;
		end else if (inc) begin
			count_next = count_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_reg <= PHYCM_RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;

endmodule : phycm_counter

module phycm_sticky (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);

	logic flag_reg;
	logic flag_next;

	// set wins over a clear in the same cycle
	always_comb begin
		flag_next = flag_reg;
		if (set) begin
			flag_next = 1'b1;
		end else if (clr) begin
			flag_next = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;

endmodule : phycm_sticky

// ### phycm_regs_properties.sv
// Purpose: port checker for the counter, mask and control register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to phycm_regs after the module
module phycm_regs_chk
	import phycm_pkg::*;
(
	input	wire logic			mclk,
	input	wire logic			rst_n,
	input	wire logic			cs_n,
	input	wire logic			ale,
	input	wire logic			rd_n,
	input	wire logic			wr_n,
	input	wire logic			ad_oe,
	input	wire logic [PHYCM_NIRQ-1:0]	irq_event,
	input	wire logic [PHYCM_NIRQ-1:0]	irq_status,
	input	wire logic			int_req,
	input	wire logic			soft_reset,
	input	wire logic			tx_clk_from_rx,
	input	wire logic [PHYCM_PORT_W-1:0]	utopia_port_addr,
	input	wire logic [PHYCM_PORT_W-1:0]	tx_addr_in,
	input	wire logic [PHYCM_PORT_W-1:0]	rx_addr_in,
	input	wire logic			tx_addr_match,
	input	wire logic			rx_addr_match
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence no_clear_s;
		rd_n && $past(rd_n) && !soft_reset;
	endsequence
	sequence wr_end1_s;
		$past(wr_n) && !$past(wr_n, 2);
	endsequence
	sequence wr_end2_s;
		$past(wr_n, 2) && !$past(wr_n, 3);
	endsequence
	oe_decode_a: assert property (
		ad_oe == (!cs_n && !rd_n && !ale)) else $error("bad ad_oe");
	int_quiet_a: assert property (
		irq_status == '0 |=> !int_req) else $error("int without status");
	int_cause_a: assert property (
		int_req |-> $past(irq_status) != '0) else $error("int no cause");
	status_set_a: assert property (
		irq_event != '0 |=> (irq_status & $past(irq_event)) ==
		$past(irq_event)) else $error("status not set");
	status_hold_a: assert property (
		no_clear_s |=> (irq_status & $past(irq_status)) ==
		$past(irq_status)) else $error("status lost");
	swrst_pulse_a: assert property (
		soft_reset |=> !soft_reset) else $error("reset pulse long");
	swrst_cause_a: assert property (
		soft_reset |-> wr_end1_s or wr_end2_s)
		else $error("reset without write");
	ctl_stable_a: assert property (
		$changed({tx_clk_from_rx, utopia_port_addr}) |-> wr_end1_s)
		else $error("control changed alone");
	tx_match_a: assert property (
		tx_addr_match == (tx_addr_in == utopia_port_addr))
		else $error("tx match wrong");
	rx_match_a: assert property (
		rx_addr_match == (rx_addr_in == utopia_port_addr))
		else $error("rx match wrong");
endmodule : phycm_regs_chk

bind phycm_regs phycm_regs_chk u_chk (.mclk, .rst_n, .cs_n, .ale, .rd_n,
	.wr_n, .ad_oe, .irq_event, .irq_status, .int_req, .soft_reset,
	.tx_clk_from_rx, .utopia_port_addr, .tx_addr_in, .rx_addr_in,
	.tx_addr_match, .rx_addr_match);

// ### phycm_host.sv
// Purpose: host processor model on the utility bus
// Assumes: requests change just after mclk rising edges
// Notes:   released bus carries the inverse of the last value
module phycm_host (
	input	wire logic [7:0]	ad_out,
	input	wire logic		mclk,
	output	logic			cs_n,
	output	logic			ale,
	output	logic			rd_n,
	output	logic			wr_n,
	output	logic [7:0]		hd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'b1;
		ale = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		hd = 8'h00;
	end
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		ale <= 1'b1;
		hd <= {3'h0, a};
		@(posedge mclk);
		ale <= 1'b0;
		@(posedge mclk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		hd <= d;
		@(posedge mclk);
		wr_n <= 1'b1;
		@(posedge mclk);
		cs_n <= 1'b1;
		hd <= ~d;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		ale <= 1'b1;
		hd <= {3'h0, a};
		@(posedge mclk);
		ale <= 1'b0;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		hd <= ~{3'h0, a};
		repeat (3) @(posedge mclk);
		d = ad_out;
		rd_n <= 1'b1;
		@(posedge mclk);
		cs_n <= 1'b1;
	endtask : rd
endmodule : phycm_host

// ### testbench.sv
// Purpose: self-checking bench of the register bank
// Assumes: host model drives the utility bus
// Notes:   event pulses come straight from the bench
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import phycm_pkg::*;
	logic		mclk, rst_n, cs_n, ale, rd_n, wr_n, ad_oe, int_req;
	logic		sym, txc, rxc, hbad, hec, soft_reset, tx_clk_from_rx;
	logic		tx_addr_match, rx_addr_match;
	logic [7:0]	hd, ad_in, ad_out;
	logic [5:0]	irq_event, irq_status;
	logic [4:0]	utopia_port_addr, tx_addr_in, rx_addr_in;
	int		err_total = 0;
	int		n_checks = 0;
	int		n_sw = 0;
	assign ad_in = ad_oe ? ad_out : hd;
	phycm_regs uut (.mclk, .rst_n, .cs_n, .ale, .rd_n, .wr_n, .ad_in,
		.ad_out, .ad_oe, .symbol_err_evt(sym), .tx_cell_evt(txc),
		.rx_cell_evt(rxc), .rx_cell_hec_bad(hbad), .rx_hec_err_evt(hec),
		.irq_event, .irq_status, .int_req, .soft_reset, .tx_clk_from_rx,
		.utopia_port_addr, .tx_addr_in, .rx_addr_in, .tx_addr_match,
		.rx_addr_match);
	phycm_host h (.mclk, .ad_out, .cs_n, .ale, .rd_n, .wr_n, .hd);
	always #2 mclk = ~mclk;
	always @(posedge mclk)
		if (soft_reset === 1'b1)
			n_sw <= n_sw + 1;
	task automatic report_and_stop;
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		h.rd(a, d);
		chk(d, e);
	endtask : rdc
	task automatic wait_req(input logic v);
		for (int k = 0; k < 8; k++) begin
			if (int_req === v)
				return;
			@(posedge mclk);
		end
		err_total++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, int_req, v);
		report_and_stop;
	endtask : wait_req
	task automatic t_reset;
		chk({3'h0, utopia_port_addr}, 8'h00);
		chk({7'h0, tx_clk_from_rx}, 8'h00);
		rdc(5'h07, 8'h00);
		rdc(5'h05, 8'h00);
		rdc(5'h06, 8'h00);
		rdc(5'h1f, 8'h00);
	endtask : t_reset
	task automatic t_count;
		for (int j = 0; j < 259; j++) begin
			@(posedge mclk);
			sym <= 1'b1;
			txc <= (j < 258);
			rxc <= 1'b1;
			hbad <= (j >= 257);
			hec <= (j < 256);
		end
		@(posedge mclk);
		{sym, txc, rxc, hec} <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			h.wr(5'h06, 8'h01 << i);
			rdc(5'h04, 8'(i));
			rdc(5'h05, 8'h01);
		end
		h.wr(5'h04, 8'hff);
		h.wr(5'h05, 8'hff);
		rdc(5'h04, 8'h03);
		rdc(5'h05, 8'h01);
	endtask : t_count
	task automatic t_irq;
		for (int b = 0; b < 6; b++) begin
			h.wr(5'h07, 8'h01 << b);
			@(posedge mclk);
			irq_event <= 6'h01 << b;
			@(posedge mclk);
			irq_event <= 6'h00;
			repeat (4) @(posedge mclk);
			chk({7'h0, int_req}, 8'h00);
			h.wr(5'h07, 8'hff ^ (8'h01 << b));
			wait_req(1'b1);
			chk({2'h0, irq_status}, 8'h01 << b);
			rdc(5'h07, 8'h3f ^ (8'h01 << b));
			rdc(5'h01, 8'h01 << b);
			wait_req(1'b0);
		end
	endtask : t_irq
	task automatic t_ctl;
		h.wr(5'h08, 8'h55);
		@(posedge mclk);
		chk({7'h0, tx_clk_from_rx}, 8'h01);
		chk({3'h0, utopia_port_addr}, 8'h15);
		rdc(5'h08, 8'h55);
		tx_addr_in <= 5'h15;
		rx_addr_in <= 5'h14;
		@(posedge mclk);
		chk({6'h0, tx_addr_match, rx_addr_match}, 8'h02);
		h.wr(5'h08, 8'hd5);
		repeat (2) @(posedge mclk);
		chk(8'(n_sw), 8'h01);
		rdc(5'h08, 8'h55);
		rdc(5'h04, 8'h00);
	endtask : t_ctl
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{sym, txc, rxc, hbad, hec} = 5'h00;
		irq_event = 6'h00;
		tx_addr_in = 5'h00;
		rx_addr_in = 5'h01;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_count;
		t_irq;
		t_ctl;
		report_and_stop;
	end
endmodule : testbench
